// ==== cbe_core.sv ====
// bit error handling, signal free time counter and data registers behind ahb-lite
`default_nettype none

// Function
// - long period error in singlecast drives error bit only when its enable is set
// - rising edge error in singlecast drives error bit only when its enable is set
// - stop rx on rising edge error if set, else sample at 1.05 ms
// - tolerance select picks standard or extended receive timing windows
// - free time codes 1 to 5 wait 1.5 to 5.5 nominal bit periods
// - free time is measured from the acknowledge bit falling edge
// - code 0 waits 3 bit periods after an unsuccessful transmission
// - code 0 waits 5 bit periods when becoming a new initiator
// - code 0 waits 7 bit periods after a successful transmission
// - write only transmit byte in bits 7:0 feeds the next byte sent
// - read only receive byte in bits 7:0 holds last byte received
// - free time starts on start request, or on enable when option is set
// - long bit period flags an error and stops reception
module cbe_core
  import cbe_pkg::*;
#(
  parameter logic [17:0] HALF_BIT_CYCLES = 18'(CBE_HALF_BIT_CYC),
  parameter logic [17:0] SAMPLE_CYCLES   = 18'(CBE_SAMPLE_CYC),
  parameter logic [17:0] STD_MIN_CYCLES  = 18'(CBE_STD_MIN_CYC),
  parameter logic [17:0] STD_MAX_CYCLES  = 18'(CBE_STD_MAX_CYC),
  parameter logic [17:0] EXT_MIN_CYCLES  = 18'(CBE_EXT_MIN_CYC),
  parameter logic [17:0] EXT_MAX_CYCLES  = 18'(CBE_EXT_MAX_CYC)
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire cbe_evt_t    evt,
  output cbe_ctl_t         ctl,
  output cbe_timing_t      timing,
  output logic             irq
);

  // ****************************************
  // state
  // ****************************************
  logic                 wr_pend_reg;
  logic                 wr_pend_next;
  logic [7:0]           addr_reg;
  logic [7:0]           addr_next;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;
  logic                 enable_reg;
  logic                 enable_next;
  logic                 start_reg;
  logic                 start_next;
  logic [CBE_CFG_W-1:0] cfg_reg;
  logic [CBE_CFG_W-1:0] cfg_next;
  logic [7:0]           tx_reg;
  logic [7:0]           tx_next;
  logic [7:0]           rx_reg;
  logic [7:0]           rx_next;
  logic [CBE_ST_W-1:0]  stat_reg;
  logic [CBE_ST_W-1:0]  stat_next;
  logic [CBE_ST_W-1:0]  mask_reg;
  logic [CBE_ST_W-1:0]  mask_next;
  logic                 errbit_reg;
  logic                 errbit_next;
  logic                 rxstop_reg;
  logic                 rxstop_next;
  cbe_sft_state_t       sft_reg;
  cbe_sft_state_t       sft_next;
  logic [17:0]          cnt_reg;
  logic [17:0]          cnt_next;
  logic [3:0]           half_reg;
  logic [3:0]           half_next;
  logic                 fail_seen_reg;
  logic                 fail_seen_next;
  logic                 ok_seen_reg;
  logic                 ok_seen_next;

  // ****************************************
  // decoded fields
  // ****************************************
  logic       addr_phase;
  logic       wr_ctl;
  logic       wr_cfg;
  logic       wr_tx;
  logic       wr_stat;
  logic       wr_mask;
  logic [2:0] sft_code;
  logic       long_period_errbit_gen;
  logic       rising_edge_errbit_gen;
  logic       rising_edge_stop_rx;
  logic       rx_tolerance_select;
  logic       free_time_start_option;
  logic [3:0] half_target;
  logic [CBE_ST_W-1:0] stat_set;
  logic       sft_arm;

  assign sft_code               = cfg_reg[CBE_CFG_SFT_MSB:CBE_CFG_SFT_LSB];
  assign rx_tolerance_select    = cfg_reg[CBE_CFG_TOL];
  assign rising_edge_stop_rx    = cfg_reg[CBE_CFG_RE_STOP];
  assign rising_edge_errbit_gen = cfg_reg[CBE_CFG_RE_GEN];
  assign long_period_errbit_gen = cfg_reg[CBE_CFG_LP_GEN];
  assign free_time_start_option = cfg_reg[CBE_CFG_OPT];

  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign addr_phase = hsel && htrans[1] && hready && ce;
  assign hreadyout  = ce;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_reg;
  assign wr_ctl     = wr_pend_reg && ce && (addr_reg == CBE_ADDR_CONTROL);
  assign wr_cfg     = wr_pend_reg && ce && (addr_reg == CBE_ADDR_CONFIG);
  assign wr_tx      = wr_pend_reg && ce && (addr_reg == CBE_ADDR_TX_BYTE);
  assign wr_stat    = wr_pend_reg && ce && (addr_reg == CBE_ADDR_STATUS);
  assign wr_mask    = wr_pend_reg && ce && (addr_reg == CBE_ADDR_MASK);

  always_comb begin
    wr_pend_next = wr_pend_reg;
    addr_next    = addr_reg;
    rdata_next   = rdata_reg;
    if (ce && hready) begin
      wr_pend_next = addr_phase && hwrite;
      addr_next    = haddr[7:0];
    end
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        CBE_ADDR_CONTROL: rdata_next = {30'h00000000, start_reg, enable_reg};
        CBE_ADDR_CONFIG:  rdata_next = {23'h000000, cfg_reg};
        CBE_ADDR_RX_BYTE: rdata_next = {24'h000000, rx_reg};
        CBE_ADDR_STATUS:  rdata_next = {26'h0000000, stat_reg};
        CBE_ADDR_MASK:    rdata_next = {26'h0000000, mask_reg};
        default:          rdata_next = 32'h00000000;
      endcase
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_comb begin
    enable_next = enable_reg;
    start_next  = start_reg;
    cfg_next    = cfg_reg;
    tx_next     = tx_reg;
    mask_next   = mask_reg;
    rx_next     = rx_reg;
    if (wr_ctl) begin
      enable_next = hwdata[CBE_CTL_ENABLE];
      if (hwdata[CBE_CTL_START] && enable_reg) begin
        start_next = 1'b1;
      end
    end
    if (evt.tx_success || evt.tx_fail) begin
      start_next = 1'b0;
    end
    if (!enable_next) begin
      start_next = 1'b0;
    end
    if (wr_cfg && !enable_reg) begin
      cfg_next = hwdata[CBE_CFG_W-1:0];
      cfg_next[7] = 1'b0;
    end
    if (wr_tx) begin
      tx_next = hwdata[7:0];
    end
    if (wr_mask) begin
      mask_next = hwdata[CBE_ST_W-1:0];
    end
    if (ce && evt.rx_valid) begin
      rx_next = evt.rx_data;
    end
  end

  // ****************************************
  // error bit and stop requests
  // ****************************************
  always_comb begin
    errbit_next = 1'b0;
    rxstop_next = 1'b0;
    if (evt.singlecast && evt.long_period && long_period_errbit_gen) begin
      errbit_next = 1'b1;
    end
    if (evt.singlecast && evt.rising_edge && rising_edge_errbit_gen) begin
      errbit_next = 1'b1;
    end
    if (evt.long_period) begin
      rxstop_next = 1'b1;
    end
    if (evt.rising_edge && rising_edge_stop_rx) begin
      rxstop_next = 1'b1;
    end
  end

  // ****************************************
  // sticky status and interrupt
  // ****************************************
  always_comb begin
    stat_set = CBE_ST_RESET;
    stat_set[CBE_ST_LONG]     = evt.long_period;
    stat_set[CBE_ST_RISE]     = evt.rising_edge;
    stat_set[CBE_ST_RX_BYTE]  = evt.rx_valid;
    stat_set[CBE_ST_TX_OK]    = evt.tx_success;
    stat_set[CBE_ST_TX_FAIL]  = evt.tx_fail || evt.arb_lost;
    stat_set[CBE_ST_SFT_DONE] = (sft_reg == CBE_COUNT) && (sft_next == CBE_DONE);
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & ~hwdata[CBE_ST_W-1:0];
    end
    stat_next = stat_next | stat_set;
  end

  assign irq = |(stat_reg & mask_reg);

  // ****************************************
  // signal free time counter
  // ****************************************
  always_comb begin
    if (sft_code == CBE_SFT_AUTO) begin
      if (fail_seen_reg) begin
        half_target = CBE_HALF_FAIL;
      end else if (ok_seen_reg) begin
        half_target = CBE_HALF_SUCCESS;
      end else begin
        half_target = CBE_HALF_NEWINIT;
      end
    end else if (sft_code > CBE_SFT_MAX_CODE) begin
      half_target = {CBE_SFT_MAX_CODE, 1'b1};
    end else begin
      half_target = {sft_code, 1'b1};
    end
  end

  assign sft_arm = enable_reg && (free_time_start_option || start_reg);

  always_comb begin
    sft_next       = sft_reg;
    cnt_next       = cnt_reg;
    half_next      = half_reg;
    fail_seen_next = fail_seen_reg || evt.tx_fail || evt.arb_lost;
    ok_seen_next   = ok_seen_reg || evt.tx_success;
    unique case (sft_reg)
      CBE_IDLE: begin
        if (sft_arm) begin
          sft_next  = CBE_COUNT;
          cnt_next  = CBE_CNT_ZERO;
          half_next = CBE_HALF_ZERO;
        end
      end
      CBE_COUNT: begin
        if (cnt_reg == HALF_BIT_CYCLES - 18'h00001) begin
          cnt_next  = CBE_CNT_ZERO;
          half_next = half_reg + 4'h1;
          if (half_reg + 4'h1 >= half_target) begin
            sft_next       = CBE_DONE;
            fail_seen_next = 1'b0;
            ok_seen_next   = 1'b0;
          end
        end else begin
          cnt_next = cnt_reg + 18'h00001;
        end
      end
      CBE_DONE: begin
        sft_next = CBE_DONE;
      end
    endcase
    if (evt.ack_fall && enable_reg) begin
      sft_next  = CBE_COUNT;
      cnt_next  = CBE_CNT_ZERO;
      half_next = CBE_HALF_ZERO;
    end
    if (!enable_reg) begin
      sft_next = CBE_IDLE;
    end
  end

  // ****************************************
  // outputs to the frame engine
  // ****************************************
  assign ctl.err_bit_req = errbit_reg;
  assign ctl.rx_stop     = rxstop_reg;
  assign ctl.sft_done    = (sft_reg == CBE_DONE);
  assign ctl.enable      = enable_reg;
  assign ctl.start_req   = start_reg;
  assign ctl.tx_data     = tx_reg;

  assign timing.sample_point = SAMPLE_CYCLES;
  assign timing.bit_min = rx_tolerance_select ? EXT_MIN_CYCLES : STD_MIN_CYCLES;
  assign timing.bit_max = rx_tolerance_select ? EXT_MAX_CYCLES : STD_MAX_CYCLES;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_reg   <= 1'b0;
      addr_reg      <= CBE_ADDR_CONTROL;
      rdata_reg     <= 32'h00000000;
      enable_reg    <= 1'b0;
      start_reg     <= 1'b0;
      cfg_reg       <= CBE_CFG_RESET;
      tx_reg        <= CBE_BYTE_RESET;
      rx_reg        <= CBE_BYTE_RESET;
      stat_reg      <= CBE_ST_RESET;
      mask_reg      <= CBE_ST_RESET;
      errbit_reg    <= 1'b0;
      rxstop_reg    <= 1'b0;
      sft_reg       <= CBE_IDLE;
      cnt_reg       <= CBE_CNT_ZERO;
      half_reg      <= CBE_HALF_ZERO;
      fail_seen_reg <= 1'b0;
      ok_seen_reg   <= 1'b0;
    end else if (ce) begin
      wr_pend_reg   <= wr_pend_next;
      addr_reg      <= addr_next;
      rdata_reg     <= rdata_next;
      enable_reg    <= enable_next;
      start_reg     <= start_next;
      cfg_reg       <= cfg_next;
      tx_reg        <= tx_next;
      rx_reg        <= rx_next;
      stat_reg      <= stat_next;
      mask_reg      <= mask_next;
      errbit_reg    <= errbit_next;
      rxstop_reg    <= rxstop_next;
      sft_reg       <= sft_next;
      cnt_reg       <= cnt_next;
      half_reg      <= half_next;
      fail_seen_reg <= fail_seen_next;
      ok_seen_reg   <= ok_seen_next;
    end
  end

endmodule
`default_nettype wire

// ==== cbe_pkg.sv ====
// constants, register map and carrier types of the bit error, free time and data block
`default_nettype none
package cbe_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] CBE_ADDR_CONTROL = 8'h00;
  localparam logic [7:0] CBE_ADDR_CONFIG  = 8'h04;
  localparam logic [7:0] CBE_ADDR_TX_BYTE = 8'h08;
  localparam logic [7:0] CBE_ADDR_RX_BYTE = 8'h0C;
  localparam logic [7:0] CBE_ADDR_STATUS  = 8'h10;
  localparam logic [7:0] CBE_ADDR_MASK    = 8'h14;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CBE_CTL_ENABLE  = 0;
  localparam int CBE_CTL_START   = 1;
  localparam int CBE_CFG_SFT_LSB = 0;
  localparam int CBE_CFG_SFT_MSB = 2;
  localparam int CBE_CFG_TOL     = 3;
  localparam int CBE_CFG_RE_STOP = 4;
  localparam int CBE_CFG_RE_GEN  = 5;
  localparam int CBE_CFG_LP_GEN  = 6;
  localparam int CBE_CFG_OPT     = 8;
  localparam int CBE_CFG_W       = 9;

  // status and mask bits
  localparam int CBE_ST_LONG     = 0;
  localparam int CBE_ST_RISE     = 1;
  localparam int CBE_ST_RX_BYTE  = 2;
  localparam int CBE_ST_TX_OK    = 3;
  localparam int CBE_ST_TX_FAIL  = 4;
  localparam int CBE_ST_SFT_DONE = 5;
  localparam int CBE_ST_W        = 6;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CBE_CFG_W-1:0] CBE_CFG_RESET = 9'h000;
  localparam logic [CBE_ST_W-1:0]  CBE_ST_RESET  = 6'h00;
  localparam logic [7:0]           CBE_BYTE_RESET = 8'h00;
  localparam logic [17:0]          CBE_CNT_ZERO  = 18'h00000;
  localparam logic [3:0]           CBE_HALF_ZERO = 4'h0;

  // ****************************************
  // free time codes and targets in half bit periods
  // ****************************************
  localparam logic [2:0] CBE_SFT_AUTO     = 3'h0;
  localparam logic [2:0] CBE_SFT_MAX_CODE = 3'h5;
  localparam logic [3:0] CBE_HALF_FAIL    = 4'h6;
  localparam logic [3:0] CBE_HALF_NEWINIT = 4'hA;
  localparam logic [3:0] CBE_HALF_SUCCESS = 4'hE;

  // ****************************************
  // timing in ns and derived cycle counts
  // ****************************************
  localparam int CBE_CLK_NS      = 20;
  localparam int CBE_BIT_NS      = 2400000;
  localparam int CBE_SAMPLE_NS   = 1050000;
  localparam int CBE_STD_MIN_NS  = 2050000;
  localparam int CBE_STD_MAX_NS  = 2750000;
  localparam int CBE_EXT_MIN_NS  = 1850000;
  localparam int CBE_EXT_MAX_NS  = 2950000;
  localparam int CBE_HALF_BIT_CYC = CBE_BIT_NS / (2 * CBE_CLK_NS);
  localparam int CBE_SAMPLE_CYC  = CBE_SAMPLE_NS / CBE_CLK_NS;
  localparam int CBE_STD_MIN_CYC = (CBE_STD_MIN_NS + CBE_CLK_NS - 1) / CBE_CLK_NS;
  localparam int CBE_STD_MAX_CYC = CBE_STD_MAX_NS / CBE_CLK_NS;
  localparam int CBE_EXT_MIN_CYC = (CBE_EXT_MIN_NS + CBE_CLK_NS - 1) / CBE_CLK_NS;
  localparam int CBE_EXT_MAX_CYC = CBE_EXT_MAX_NS / CBE_CLK_NS;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       long_period;
    logic       rising_edge;
    logic       singlecast;
    logic       ack_fall;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_success;
    logic       tx_fail;
    logic       arb_lost;
  } cbe_evt_t;

  typedef struct packed {
    logic       err_bit_req;
    logic       rx_stop;
    logic       sft_done;
    logic       enable;
    logic       start_req;
    logic [7:0] tx_data;
  } cbe_ctl_t;

  typedef struct packed {
    logic [17:0] sample_point;
    logic [17:0] bit_min;
    logic [17:0] bit_max;
  } cbe_timing_t;

  typedef enum logic [2:0] {
    CBE_IDLE  = 3'b001,
    CBE_COUNT = 3'b010,
    CBE_DONE  = 3'b100
  } cbe_sft_state_t;

endpackage
`default_nettype wire

// ==== cbe_pkg_unused_guard.sv ====
// intentionally no content beyond an empty compilation unit
`default_nettype none
`default_nettype wire

// ==== cbe_core_sva.sv ====
// assertion checker for the bit error, free time and data block
`default_nettype none
module cbe_core_sva
  import cbe_pkg::*;
#(
  parameter logic [17:0] HALF_BIT_CYCLES = 18'(CBE_HALF_BIT_CYC)
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire cbe_evt_t    evt,
  input wire cbe_ctl_t    ctl,
  input wire cbe_timing_t timing,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // helpers: pending tx write, cycles since enable or ack edge
  // ******
  logic        tx_wr_reg;
  logic        tx_wr_next;
  logic [17:0] run_reg;
  logic [17:0] run_next;
  always_comb begin
    tx_wr_next = rst_n & hsel & htrans[1] & hready & ce & hwrite
               & (haddr[7:0] == CBE_ADDR_TX_BYTE);
    run_next = run_reg;
    if (!rst_n || evt.ack_fall || !ctl.enable) begin
      run_next = CBE_CNT_ZERO;
    end else if (ce && !ctl.sft_done) begin
      run_next = run_reg + 18'h00001;
    end
  end
  always_ff @(posedge clk) begin
    tx_wr_reg <= tx_wr_next;
    run_reg   <= run_next;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_err_cause: assert property (ctl.err_bit_req |->
    $past(evt.singlecast) && $past(evt.long_period || evt.rising_edge))
    else $error("error bit without singlecast error");
  chk_long_stop: assert property (ce && evt.long_period |=> ctl.rx_stop)
    else $error("long period did not stop reception");
  chk_stop_cause: assert property (ctl.rx_stop |->
    $past(evt.long_period || evt.rising_edge)) else $error("stop without cause");
  chk_tol_pair: assert property ((timing.bit_min < 18'(CBE_STD_MIN_CYC)) ==
    (timing.bit_max > 18'(CBE_STD_MAX_CYC))) else $error("tolerance windows disagree");
  chk_ack_restart: assert property (ce && evt.ack_fall && ctl.enable |=> !ctl.sft_done)
    else $error("ack edge did not restart free time");
  chk_sft_min: assert property ($rose(ctl.sft_done) |->
    run_reg >= 3 * HALF_BIT_CYCLES - 18'h2) else $error("free time too short");
  chk_tx_write: assert property (tx_wr_reg |=> ctl.tx_data == $past(hwdata[7:0]))
    else $error("tx byte not written");
  chk_bus_okay: assert property (hresp == 1'b0) else $error("response not okay");
  chk_ready_ce: assert property (hreadyout == ce) else $error("ready not following ce");
endmodule
bind cbe_core cbe_core_sva #(.HALF_BIT_CYCLES(HALF_BIT_CYCLES)) cbe_core_sva_inst (
  .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt), .ctl(ctl),
  .timing(timing), .irq(irq)
);
`default_nettype wire

// ==== cbe_line_model.sv ====
// model of the other line devices, reduced to the events they cause
`default_nettype none
module cbe_line_model
  import cbe_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] kind,
  input  wire logic       cast,
  input  wire logic [7:0] data,
  output var  cbe_evt_t   evt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // one cycle event pulses
  // ******
  cbe_evt_t evt_next;
  always_comb begin
    evt_next             = '0;
    evt_next.singlecast  = cast;
    evt_next.long_period = go & (kind == 4'h0);
    evt_next.rising_edge = go & (kind == 4'h1);
    evt_next.ack_fall    = go & (kind == 4'h2);
    evt_next.rx_valid    = go & (kind == 4'h3);
    evt_next.tx_success  = go & (kind == 4'h4);
    evt_next.tx_fail     = go & (kind == 4'h5);
    evt_next.arb_lost    = go & (kind == 4'h6);
    evt_next.rx_data     = (go && kind == 4'h3) ? data : ~data;
  end
  always_ff @(posedge clk) begin
    evt <= evt_next;
  end
endmodule
`default_nettype wire

// ==== cbe_core_tb_top.sv ====
// self-checking bench for the bit error, free time and data block
`default_nettype none
module cbe_core_tb_top
  import cbe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ******
  // signals, design and line model
  // ******
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        go = 1'b0, cast = 1'b0, hreadyout, hresp, irq;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  kind = 4'h0;
  logic [7:0]  data = 8'h00;
  cbe_evt_t    evt;
  cbe_ctl_t    ctl;
  cbe_timing_t timing;
  int          mismatches = 0, samples_checked = 0, n_err = 0, n_stop = 0;
  localparam int HB = 4;
  cbe_core #(.HALF_BIT_CYCLES(18'(HB))) cbe_core_inst (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt(evt), .ctl(ctl),
    .timing(timing), .irq(irq)
  );
  cbe_line_model cbe_line_model_inst (
    .clk(clk), .go(go), .kind(kind), .cast(cast), .data(data), .evt(evt)
  );
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    n_err  <= n_err + int'(ctl.err_bit_req === 1'b1);
    n_stop <= n_stop + int'(ctl.rx_stop === 1'b1);
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      chk(32'h0, 32'h1, "bus hang");
      summarize();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e, m);
  endtask
  task automatic ev(input logic [3:0] k, input logic s, input logic [7:0] d);
    go   <= 1'b1;
    kind <= k;
    cast <= s;
    data <= d;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic sft(input int halves, input int lead, input string m);
    int n;
    n = 0;
    while (ctl.sft_done !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    chk(32'(n), 32'(halves * HB + lead), m);
    if (n >= 400) begin
      summarize();
    end
  endtask
  // ******
  // tests
  // ******
  initial begin
    int e;
    int s;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(CBE_ADDR_CONFIG, 32'h0, "config reset");
    rd(CBE_ADDR_TX_BYTE, 32'h0, "tx reset");
    rd(CBE_ADDR_RX_BYTE, 32'h0, "rx reset");
    rd(8'h18, 32'h0, "unmapped");
    wr(CBE_ADDR_CONFIG, 32'h1FF);
    rd(CBE_ADDR_CONFIG, 32'h17F, "config rw");
    wr(CBE_ADDR_CONTROL, 32'h1);
    wr(CBE_ADDR_CONFIG, 32'h0);
    rd(CBE_ADDR_CONFIG, 32'h17F, "config locked");
    wr(CBE_ADDR_CONTROL, 32'h0);
    $display("test registers finished");
    for (int i = 0; i < 5; i++) begin
      wr(CBE_ADDR_CONFIG, (i < 3) ? 32'h40 : 32'h30);
      e = n_err;
      s = n_stop;
      ev(4'((5'b01010 >> i) & 5'h1), 1'((5'b11011 >> i) & 5'h1), 8'h00);
      chk(32'(n_err - e), 32'(5'b01001 >> i & 5'h1), "error bit");
      chk(32'(n_stop - s), 32'(5'b11101 >> i & 5'h1), "stop");
    end
    rd(CBE_ADDR_STATUS, 32'h03, "error status");
    wr(CBE_ADDR_MASK, 32'h02);
    @(posedge clk);
    chk({31'h0, irq}, 32'h1, "irq set");
    wr(CBE_ADDR_STATUS, 32'h02);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd(CBE_ADDR_STATUS, 32'h01, "w1c");
    $display("test errors finished");
    ev(4'h3, 1'b0, 8'h5A);
    rd(CBE_ADDR_RX_BYTE, 32'h5A, "rx byte");
    wr(CBE_ADDR_RX_BYTE, 32'hFF);
    rd(CBE_ADDR_RX_BYTE, 32'h5A, "rx read only");
    wr(CBE_ADDR_TX_BYTE, 32'h123456C3);
    @(posedge clk);
    chk({24'h0, ctl.tx_data}, 32'hC3, "tx byte");
    rd(CBE_ADDR_TX_BYTE, 32'h0, "tx write only");
    for (int t = 0; t < 2; t++) begin
      wr(CBE_ADDR_CONFIG, (t == 1) ? 32'h8 : 32'h0);
      @(posedge clk);
      chk({14'h0, timing.bit_min},
          (t == 1) ? 32'(CBE_EXT_MIN_CYC) : 32'(CBE_STD_MIN_CYC), "bit min");
      chk({14'h0, timing.bit_max},
          (t == 1) ? 32'(CBE_EXT_MAX_CYC) : 32'(CBE_STD_MAX_CYC), "bit max");
      chk({14'h0, timing.sample_point}, 32'(CBE_SAMPLE_CYC), "sample point");
    end
    $display("test data finished");
    for (int c = 1; c < 8; c++) begin
      wr(CBE_ADDR_CONFIG, 32'h100 | 32'(c));
      wr(CBE_ADDR_CONTROL, 32'h1);
      sft((c > 5) ? 11 : 2 * c + 1, 2, "fixed free time");
      wr(CBE_ADDR_CONTROL, 32'h0);
    end
    wr(CBE_ADDR_CONFIG, 32'h100);
    wr(CBE_ADDR_CONTROL, 32'h1);
    sft(10, 2, "new initiator");
    for (int k = 0; k < 3; k++) begin
      ev(4'(k + 4), 1'b0, 8'h00);
      ev(4'h2, 1'b0, 8'h00);
      sft((k == 0) ? 14 : 6, -1, "after outcome");
    end
    wr(CBE_ADDR_CONTROL, 32'h0);
    wr(CBE_ADDR_CONFIG, 32'h2);
    wr(CBE_ADDR_CONTROL, 32'h1);
    repeat (40) @(posedge clk);
    chk({31'h0, ctl.sft_done}, 32'h0, "no auto start");
    wr(CBE_ADDR_CONTROL, 32'h3);
    repeat (3) @(posedge clk);
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    sft(5, -1, "start request frozen");
    rd(CBE_ADDR_CONTROL, 32'h3, "start pending");
    ev(4'h4, 1'b0, 8'h00);
    rd(CBE_ADDR_CONTROL, 32'h1, "start cleared");
    $display("test free time finished");
    summarize();
  end
endmodule
`default_nettype wire
